// ### design/pm_pad_reg.sv
`timescale 1ns/10ps
module pm_pad_reg import pm_pkg::*; #(
  parameter int N = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [N-1:0] out_nxt,
  input wire logic [N-1:0] oe_nxt,
  output logic [N-1:0] out_r,
  output logic [N-1:0] oe_r
);
  initial begin
    if (N < 1) $error("pm_pad_reg: N must be at least 1");
  end

  // Pads float during reset so that straps can be read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_r <= '0;
      oe_r <= '0;
    end else if (ce) begin
      out_r <= out_nxt;
      oe_r <= oe_nxt;
    end
  end
endmodule : pm_pad_reg

// ### design/pm_params.svh
`ifndef PM_PARAMS_SVH
`define PM_PARAMS_SVH

// --------------------------------------------------------------
// Register indices (byte address is four times the index)
// --------------------------------------------------------------
`define PM_IDX_GLOBAL_OPTION_CFG 6'h24
`define PM_IDX_GLOBAL_OPTION_CFG2 6'h26
`define PM_IDX_PIN_SELECT_CFG_A 6'h2A
`define PM_IDX_PIN_SELECT_CFG_B 6'h2B
`define PM_IDX_PORT2_ALT 6'h30
`define PM_IDX_PORT2_DIR 6'h31
`define PM_IDX_PORT2_DATA 6'h32
`define PM_IDX_PORT2_PINS 6'h33
`define PM_IDX_PM_CTL 6'h34
`define PM_IDX_PIN_STATUS 6'h35

// --------------------------------------------------------------
// Field positions
// --------------------------------------------------------------
`define PM_B_CLEAR_DEFAULTS 0
`define PM_B_KEYBOARD_ENABLE 2
`define PM_B_CLOCK48_SELECT 6
`define PM_B_CFG_PORT_ADDR 6
`define PM_B_CFGB_SEL43_LO 3
`define PM_B_CFGB_SEL5 5
`define PM_B_CFGB_SEL76_LO 6
`define PM_B_CFGA_SEL54_LO 4
`define PM_B_CFGA_SEL32_LO 2
`define PM_B_LEGACY_PM 0

// --------------------------------------------------------------
// Reset values and fixed codes
// --------------------------------------------------------------
`define PM_RST_CFG 8'h00
`define PM_CFG_ADDR_HI 16'h0370
`define PM_RESP_OKAY 2'h0
`define PM_RESP_SLVERR 2'h2

// --------------------------------------------------------------
// Pad and line indices
// --------------------------------------------------------------
`define PM_PAD_P20 0
`define PM_PAD_SMI 1
`define PM_PAD_PSWO 2
`define PM_PAD_PSWI 3
`define PM_PAD_CIR 4
`define PM_PAD_FIR 5
`define PM_KL13 0
`define PM_KL14 1
`define PM_KL15 2
`define PM_KL16 3
`define PM_KL20 4
`define PM_KL21 5
`define PM_STRAP_CHAN_A_REQUEST_TO_SEND 0
`define PM_STRAP_CHAN_A_TERMINAL_READY 1
`define PM_STRAP_CHAN_A_SERIAL_OUT 2
`define PM_STRAP_CHAN_B_SERIAL_OUT 3

`endif

// ### design/pm_pin_mux.sv
// Behaviour
// - Port2 line0 alternate is keyboard reset (line20)
// - Cfg B 4:3 selects SYS_MGMT_IRQ_N, port2 line1, line16
// - Legacy mode: SYS_MGMT_IRQ_N pulled low on PM event
// - Cfg B bit5 selects panel out or line2
// - Cfg B 7:6 selects panel in or line3
// - Cfg A 5:4 selects CIR, line4, line13
// - Cfg A 3:2 selects FIR, IR sel0, line5
// - Chan A RTS is address strap at reset
// - Address strap presets cfg2 bit6, 370H
// - Chan A DTR strap presets clear-defaults bit
// - Chan A serial out presets keyboard enable
// - Chan B serial out presets 48 MHz bit
// - Option bit6 picks 24 or 48 MHz
`timescale 1ns/10ps
`include "pm_params.svh"
module pm_pin_mux import pm_pkg::*; #(
  parameter int AW = 8,
  parameter logic [15:0] CFG_ADDR_LO = 16'h03F0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] mux_pad_in,
  output logic [5:0] mux_pad_out,
  output logic [5:0] mux_pad_oe,
  input wire logic [3:0] ser_pad_in,
  output logic [3:0] ser_pad_out,
  output logic [3:0] ser_pad_oe,
  input wire logic [3:0] ser_uart_out,
  input wire logic [5:0] keyboard_ctl_line_out,
  input wire logic [5:0] keyboard_ctl_line_oe,
  output logic [5:0] keyboard_ctl_line_in,
  input wire logic pm_event,
  input wire logic panel_switch_out,
  input wire logic ir_module_sel0,
  output logic panel_switch_in,
  output logic consumer_ir_rx,
  output logic fast_ir_rx,
  output logic clock48_select_bit,
  output logic keyboard_enable_bit,
  output logic clear_defaults_bit,
  output logic [15:0] cfg_port_addr
);
  initial begin
    if (AW < 8) $error("pm_pin_mux: AW must be at least 8");
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  pm_byte_t global_option_cfg_r;
  pm_byte_t global_option_cfg2_r;
  pm_byte_t pin_select_cfg_a_r;
  pm_byte_t pin_select_cfg_b_r;
  logic [5:0] port2_alt_r;
  logic [5:0] port2_dir_r;
  logic [5:0] port2_data_r;
  logic legacy_pm_r;
  logic strap_load_r;
  logic [5:0] port2_pins_r;
  logic [5:0] pad_out_nxt;
  logic [5:0] pad_oe_nxt;
  logic [5:0] kin_nxt;
  logic [3:0] ser_out_nxt;
  logic [3:0] ser_oe_nxt;
  pm_sel_e sel_smi;
  pm_sel_e sel_pswi;
  pm_sel_e sel_cir;
  pm_sel_e sel_fir;
  logic sel_pswo;
  pm_wr_e wr_st_r;
  pm_rd_e rd_st_r;
  logic wr_fire;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  logic wr_en;
  logic rd_hit;
  logic [7:0] rd_byte;

  pm_strap_if #(.N(4)) strap ();

  // ------------------------------------------------------------
  // Strap capture
  // ------------------------------------------------------------
  assign strap.level = ser_pad_in;

  pm_strap_latch u_strap (
    .aclk(aclk),
    .aresetn(aresetn),
    .st(strap.latch)
  );

  // Set during reset, cleared on the first edge after release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_load_r <= 1'b1;
    end else if (ce) begin
      strap_load_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite write channel
  // ------------------------------------------------------------
  assign wr_fire = (wr_st_r == PM_WR_IDLE) && s_axi_awvalid
    && s_axi_wvalid && !strap_load_r;
  assign wr_idx = s_axi_awaddr[7:2];
  assign wr_en = wr_fire && s_axi_wstrb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_st_r <= PM_WR_IDLE;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PM_RESP_OKAY;
    end else if (ce) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      case (wr_st_r)
        PM_WR_IDLE: begin
          if (wr_fire) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bresp <= (wr_idx == `PM_IDX_GLOBAL_OPTION_CFG
              || wr_idx == `PM_IDX_GLOBAL_OPTION_CFG2
              || wr_idx == `PM_IDX_PIN_SELECT_CFG_A
              || wr_idx == `PM_IDX_PIN_SELECT_CFG_B
              || wr_idx == `PM_IDX_PORT2_ALT
              || wr_idx == `PM_IDX_PORT2_DIR
              || wr_idx == `PM_IDX_PORT2_DATA
              || wr_idx == `PM_IDX_PM_CTL)
              ? `PM_RESP_OKAY : `PM_RESP_SLVERR;
            wr_st_r <= PM_WR_RESP;
          end
        end
        PM_WR_RESP: begin
          s_axi_bvalid <= 1'b1;
          if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_st_r <= PM_WR_IDLE;
          end
        end
        default: wr_st_r <= PM_WR_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      global_option_cfg_r <= `PM_RST_CFG;
      global_option_cfg2_r <= `PM_RST_CFG;
      pin_select_cfg_a_r <= `PM_RST_CFG;
      pin_select_cfg_b_r <= `PM_RST_CFG;
      port2_alt_r <= '0;
      port2_dir_r <= '0;
      port2_data_r <= '0;
      legacy_pm_r <= 1'b0;
    end else if (ce) begin
      if (strap_load_r) begin
        global_option_cfg_r[`PM_B_CLEAR_DEFAULTS] <=
          strap.held[`PM_STRAP_CHAN_A_TERMINAL_READY];
        global_option_cfg_r[`PM_B_KEYBOARD_ENABLE] <=
          strap.held[`PM_STRAP_CHAN_A_SERIAL_OUT];
        global_option_cfg_r[`PM_B_CLOCK48_SELECT] <=
          strap.held[`PM_STRAP_CHAN_B_SERIAL_OUT];
        global_option_cfg2_r[`PM_B_CFG_PORT_ADDR] <=
          strap.held[`PM_STRAP_CHAN_A_REQUEST_TO_SEND];
      end else if (wr_en) begin
        case (wr_idx)
          `PM_IDX_GLOBAL_OPTION_CFG:
            global_option_cfg_r <= s_axi_wdata[7:0];
          `PM_IDX_GLOBAL_OPTION_CFG2:
            global_option_cfg2_r <= s_axi_wdata[7:0];
          `PM_IDX_PIN_SELECT_CFG_A:
            pin_select_cfg_a_r <= s_axi_wdata[7:0];
          `PM_IDX_PIN_SELECT_CFG_B:
            pin_select_cfg_b_r <= s_axi_wdata[7:0];
          `PM_IDX_PORT2_ALT: port2_alt_r <= s_axi_wdata[5:0];
          `PM_IDX_PORT2_DIR: port2_dir_r <= s_axi_wdata[5:0];
          `PM_IDX_PORT2_DATA: port2_data_r <= s_axi_wdata[5:0];
          `PM_IDX_PM_CTL:
            legacy_pm_r <= s_axi_wdata[`PM_B_LEGACY_PM];
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read channel
  // ------------------------------------------------------------
  assign rd_idx = s_axi_araddr[7:2];

  always_comb begin
    rd_hit = 1'b1;
    rd_byte = 8'h00;
    case (rd_idx)
      `PM_IDX_GLOBAL_OPTION_CFG: rd_byte = global_option_cfg_r;
      `PM_IDX_GLOBAL_OPTION_CFG2: rd_byte = global_option_cfg2_r;
      `PM_IDX_PIN_SELECT_CFG_A: rd_byte = pin_select_cfg_a_r;
      `PM_IDX_PIN_SELECT_CFG_B: rd_byte = pin_select_cfg_b_r;
      `PM_IDX_PORT2_ALT: rd_byte = {2'h0, port2_alt_r};
      `PM_IDX_PORT2_DIR: rd_byte = {2'h0, port2_dir_r};
      `PM_IDX_PORT2_DATA: rd_byte = {2'h0, port2_data_r};
      `PM_IDX_PORT2_PINS: rd_byte = {2'h0, port2_pins_r};
      `PM_IDX_PM_CTL: rd_byte = {7'h00, legacy_pm_r};
      `PM_IDX_PIN_STATUS:
        rd_byte = {5'h00, fast_ir_rx, consumer_ir_rx,
          panel_switch_in};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_st_r <= PM_RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PM_RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= 1'b0;
      case (rd_st_r)
        PM_RD_IDLE: begin
          if (s_axi_arvalid && !strap_load_r) begin
            s_axi_arready <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_hit ? `PM_RESP_OKAY : `PM_RESP_SLVERR;
            rd_st_r <= PM_RD_DATA;
          end
        end
        PM_RD_DATA: begin
          s_axi_rvalid <= 1'b1;
          if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_st_r <= PM_RD_IDLE;
          end
        end
        default: rd_st_r <= PM_RD_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pin routing
  // ------------------------------------------------------------
  assign sel_smi = pm_sel_e'(pin_select_cfg_b_r[4:3]);
  assign sel_pswo = pin_select_cfg_b_r[`PM_B_CFGB_SEL5];
  assign sel_pswi = pm_sel_e'(pin_select_cfg_b_r[7:6]);
  assign sel_cir = pm_sel_e'(pin_select_cfg_a_r[5:4]);
  assign sel_fir = pm_sel_e'(pin_select_cfg_a_r[3:2]);

  // Port line i on pad p: alternate keyboard line k or plain bit
  function automatic logic [1:0] port_drive(input int i,
      input int k);
    if (port2_alt_r[i]) begin
      port_drive = {keyboard_ctl_line_out[k],
        keyboard_ctl_line_oe[k]};
    end else begin
      port_drive = {port2_data_r[i], port2_dir_r[i]};
    end
  endfunction : port_drive

  always_comb begin
    pad_out_nxt = '0;
    pad_oe_nxt = '0;
    kin_nxt = '1;
    {pad_out_nxt[`PM_PAD_P20], pad_oe_nxt[`PM_PAD_P20]} =
      port_drive(0, `PM_KL20);
    if (port2_alt_r[0]) kin_nxt[`PM_KL20] = mux_pad_in[`PM_PAD_P20];
    case (sel_smi)
      PM_SEL_BASE: pad_oe_nxt[`PM_PAD_SMI] = legacy_pm_r
        && pm_event;
      PM_SEL_PORT: begin
        {pad_out_nxt[`PM_PAD_SMI], pad_oe_nxt[`PM_PAD_SMI]} =
          port_drive(1, `PM_KL13);
        if (port2_alt_r[1])
          kin_nxt[`PM_KL13] = mux_pad_in[`PM_PAD_SMI];
      end
      PM_SEL_ALT: begin
        pad_out_nxt[`PM_PAD_SMI] = keyboard_ctl_line_out[`PM_KL16];
        pad_oe_nxt[`PM_PAD_SMI] = keyboard_ctl_line_oe[`PM_KL16];
        kin_nxt[`PM_KL16] = mux_pad_in[`PM_PAD_SMI];
      end
      default: ;
    endcase
    if (sel_pswo) begin
      {pad_out_nxt[`PM_PAD_PSWO], pad_oe_nxt[`PM_PAD_PSWO]} =
        port_drive(2, `PM_KL14);
      if (port2_alt_r[2])
        kin_nxt[`PM_KL14] = mux_pad_in[`PM_PAD_PSWO];
    end else begin
      pad_oe_nxt[`PM_PAD_PSWO] = panel_switch_out;
    end
    if (sel_pswi == PM_SEL_PORT) begin
      {pad_out_nxt[`PM_PAD_PSWI], pad_oe_nxt[`PM_PAD_PSWI]} =
        port_drive(3, `PM_KL15);
      if (port2_alt_r[3])
        kin_nxt[`PM_KL15] = mux_pad_in[`PM_PAD_PSWI];
    end
    case (sel_cir)
      PM_SEL_PORT: begin
        {pad_out_nxt[`PM_PAD_CIR], pad_oe_nxt[`PM_PAD_CIR]} =
          port_drive(4, `PM_KL16);
        if (port2_alt_r[4])
          kin_nxt[`PM_KL16] = kin_nxt[`PM_KL16]
            & mux_pad_in[`PM_PAD_CIR];
      end
      PM_SEL_ALT: begin
        pad_out_nxt[`PM_PAD_CIR] = keyboard_ctl_line_out[`PM_KL13];
        pad_oe_nxt[`PM_PAD_CIR] = keyboard_ctl_line_oe[`PM_KL13];
        kin_nxt[`PM_KL13] = kin_nxt[`PM_KL13]
          & mux_pad_in[`PM_PAD_CIR];
      end
      default: ;
    endcase
    case (sel_fir)
      PM_SEL_PORT: begin
        pad_out_nxt[`PM_PAD_FIR] = ir_module_sel0;
        pad_oe_nxt[`PM_PAD_FIR] = 1'b1;
      end
      PM_SEL_ALT: begin
        {pad_out_nxt[`PM_PAD_FIR], pad_oe_nxt[`PM_PAD_FIR]} =
          port_drive(5, `PM_KL21);
        if (port2_alt_r[5])
          kin_nxt[`PM_KL21] = mux_pad_in[`PM_PAD_FIR];
      end
      default: ;
    endcase
    ser_out_nxt = ser_uart_out;
    ser_oe_nxt = '1;
  end

  pm_pad_reg #(.N(6)) u_mux_pads (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .out_nxt(pad_out_nxt),
    .oe_nxt(pad_oe_nxt),
    .out_r(mux_pad_out),
    .oe_r(mux_pad_oe)
  );

  pm_pad_reg #(.N(4)) u_ser_pads (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .out_nxt(ser_out_nxt),
    .oe_nxt(ser_oe_nxt),
    .out_r(ser_pad_out),
    .oe_r(ser_pad_oe)
  );

  // ------------------------------------------------------------
  // Inputs seen through the pads and configuration outputs
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      keyboard_ctl_line_in <= '1;
      port2_pins_r <= '0;
      panel_switch_in <= 1'b1;
      consumer_ir_rx <= 1'b1;
      fast_ir_rx <= 1'b1;
    end else if (ce) begin
      keyboard_ctl_line_in <= kin_nxt;
      port2_pins_r <= mux_pad_in;
      panel_switch_in <= (sel_pswi == PM_SEL_BASE)
        ? mux_pad_in[`PM_PAD_PSWI] : 1'b1;
      consumer_ir_rx <= (sel_cir == PM_SEL_BASE)
        ? mux_pad_in[`PM_PAD_CIR] : 1'b1;
      fast_ir_rx <= (sel_fir == PM_SEL_BASE)
        ? mux_pad_in[`PM_PAD_FIR] : 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock48_select_bit <= 1'b0;
      keyboard_enable_bit <= 1'b0;
      clear_defaults_bit <= 1'b0;
      cfg_port_addr <= CFG_ADDR_LO;
    end else if (ce) begin
      clock48_select_bit <=
        global_option_cfg_r[`PM_B_CLOCK48_SELECT];
      keyboard_enable_bit <=
        global_option_cfg_r[`PM_B_KEYBOARD_ENABLE];
      clear_defaults_bit <=
        global_option_cfg_r[`PM_B_CLEAR_DEFAULTS];
      cfg_port_addr <= global_option_cfg2_r[`PM_B_CFG_PORT_ADDR]
        ? `PM_CFG_ADDR_HI : CFG_ADDR_LO;
    end
  end
endmodule : pm_pin_mux

// ### design/pm_pkg.sv
package pm_pkg;
  typedef enum logic [1:0] {
    PM_SEL_BASE,
    PM_SEL_PORT,
    PM_SEL_ALT,
    PM_SEL_NONE
  } pm_sel_e;

  typedef enum logic [1:0] {
    PM_WR_IDLE,
    PM_WR_RESP
  } pm_wr_e;

  typedef enum logic [1:0] {
    PM_RD_IDLE,
    PM_RD_DATA
  } pm_rd_e;

  typedef logic [7:0] pm_byte_t;
endpackage : pm_pkg

// ### design/pm_strap_if.sv
`timescale 1ns/10ps
interface pm_strap_if #(parameter int N = 4);
  logic [N-1:0] level;
  logic [N-1:0] held;
  modport latch (input level, output held);
  modport user (output level, input held);
endinterface : pm_strap_if

// ### design/pm_strap_latch.sv
`timescale 1ns/10ps
module pm_strap_latch import pm_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  pm_strap_if.latch st
);
  // Follows the strap pins while reset is low; holds the last level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st.held <= st.level;
    end
  end
endmodule : pm_strap_latch

// ### test/pm_board_model.sv
`timescale 1ns/10ps
module pm_board_model (
  input wire logic [5:0] mux_pad_out,
  input wire logic [5:0] mux_pad_oe,
  input wire logic [3:0] ser_pad_out,
  input wire logic [3:0] ser_pad_oe,
  input wire logic [5:0] ext_level,
  input wire logic [5:0] ext_drive,
  input wire logic [3:0] strap_pull,
  output logic [5:0] mux_pad_in,
  output logic [3:0] ser_pad_in
);
  // ----------------------------------------------------------
  // Pad wires
  // ----------------------------------------------------------
  // Shared pads carry board pull-ups for the open-drain functions
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (mux_pad_oe[i]) mux_pad_in[i] = mux_pad_out[i];
      else if (ext_drive[i]) mux_pad_in[i] = ext_level[i];
      else mux_pad_in[i] = 1'h1;
    end
  end
  // Released serial pads settle to their strap resistor
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ser_pad_in[i] = ser_pad_oe[i] ? ser_pad_out[i]
        : strap_pull[i];
    end
  end
endmodule : pm_board_model

// ### test/pm_pin_mux_assertions.sv
`timescale 1ns/10ps
`include "pm_params.svh"
module pm_pin_mux_assertions import pm_pkg::*; #(
  parameter int AW = 8,
  parameter logic [15:0] CFG_ADDR_LO = 16'h03F0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [5:0] mux_pad_in,
  input wire logic [5:0] mux_pad_out,
  input wire logic [5:0] mux_pad_oe,
  input wire logic [3:0] ser_pad_in,
  input wire logic [5:0] keyboard_ctl_line_out,
  input wire logic [5:0] keyboard_ctl_line_oe,
  input wire logic pm_event,
  input wire logic panel_switch_out,
  input wire logic panel_switch_in,
  input wire logic consumer_ir_rx,
  input wire logic fast_ir_rx,
  input wire logic clock48_select_bit,
  input wire logic keyboard_enable_bit,
  input wire logic clear_defaults_bit,
  input wire logic [15:0] cfg_port_addr
);
  // ----------------------------------------------------------
  // Shadow of accepted writes and reset tracking
  // ----------------------------------------------------------
  logic [7:0] cfg_a_r, cfg_b_r, alt_r;
  logic legacy_r, ok;
  logic [1:0] up_r;
  logic [3:0] strap_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_a_r <= `PM_RST_CFG;
      cfg_b_r <= `PM_RST_CFG;
      alt_r <= `PM_RST_CFG;
      legacy_r <= 1'h0;
    end else if (s_axi_awready && s_axi_wstrb[0] &&
                 s_axi_bresp == `PM_RESP_OKAY) begin
      case (s_axi_awaddr[7:2])
        `PM_IDX_PIN_SELECT_CFG_A: cfg_a_r <= s_axi_wdata[7:0];
        `PM_IDX_PIN_SELECT_CFG_B: cfg_b_r <= s_axi_wdata[7:0];
        `PM_IDX_PORT2_ALT: alt_r <= s_axi_wdata[7:0];
        `PM_IDX_PM_CTL: legacy_r <= s_axi_wdata[0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_r <= 2'h0;
      strap_r <= ser_pad_in;
    end else if (up_r != 2'h3) begin
      up_r <= up_r + 2'h1;
    end
  end
  // Settled: out of reset and no config write landing
  assign ok = up_r == 2'h3 && !s_axi_awready;

  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_loaded;
    up_r == 2'h2;
  endsequence
  sequence s_smi_low;
    mux_pad_oe[1] && !mux_pad_out[1];
  endsequence
  a_strap_addr: assert property (
    s_loaded |-> cfg_port_addr == (strap_r[0] ? `PM_CFG_ADDR_HI : CFG_ADDR_LO))
    else $error("config port address not from strap");
  a_strap_bits: assert property (
    s_loaded |-> {clock48_select_bit, keyboard_enable_bit, clear_defaults_bit}
      == {strap_r[3], strap_r[2], strap_r[1]})
    else $error("option bits not from straps");
  a_smi_pull: assert property (
    ok && cfg_b_r[4:3] == 2'h0 && legacy_r && pm_event |=> s_smi_low)
    else $error("management interrupt not pulled low");
  a_panel_out: assert property (
    ok && !cfg_b_r[5] && panel_switch_out |=> mux_pad_oe[2] && !mux_pad_out[2])
    else $error("panel output not pulled low");
  a_panel_in: assert property (
    ok && cfg_b_r[7:6] == 2'h0 |=> panel_switch_in == $past(mux_pad_in[3]))
    else $error("panel input not from pad");
  a_cir_rx: assert property (
    ok && cfg_a_r[5:4] == 2'h0 |=> consumer_ir_rx == $past(mux_pad_in[4]))
    else $error("consumer ir input not from pad");
  a_fir_rx: assert property (
    ok && cfg_a_r[3:2] == 2'h0 |=> fast_ir_rx == $past(mux_pad_in[5]))
    else $error("fast ir input not from pad");
  a_kbd_reset: assert property (
    ok && alt_r[0] && keyboard_ctl_line_oe[4] |=> mux_pad_oe[0] &&
      mux_pad_out[0] == $past(keyboard_ctl_line_out[4]))
    else $error("keyboard reset not on port line 0");
endmodule : pm_pin_mux_assertions

bind pm_pin_mux pm_pin_mux_assertions #(
  .AW(AW),
  .CFG_ADDR_LO(CFG_ADDR_LO)
) u_pm_pin_mux_assertions (.*);

// ### test/pm_pin_mux_tb_top.sv
`timescale 1ns/10ps
`include "pm_params.svh"
module pm_pin_mux_tb_top import pm_pkg::*; ;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic ce = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [5:0] mux_pad_in, mux_pad_out, mux_pad_oe, keyboard_ctl_line_in;
  logic [3:0] ser_pad_in, ser_pad_out, ser_pad_oe;
  logic [3:0] ser_uart_out = 4'h5;
  logic [5:0] keyboard_ctl_line_out = 6'h00, keyboard_ctl_line_oe = 6'h00;
  logic pm_event = 1'h0, panel_switch_out = 1'h0, ir_module_sel0 = 1'h0;
  logic panel_switch_in, consumer_ir_rx, fast_ir_rx;
  logic clock48_select_bit, keyboard_enable_bit, clear_defaults_bit;
  logic [15:0] cfg_port_addr;
  logic [5:0] ext_level = 6'h00, ext_drive = 6'h38;
  logic [3:0] strap_pull = 4'hB;
  logic [31:0] rd_v;
  int failures = 0;
  int total_checks = 0;

  pm_pin_mux u_pm_pin_mux (.*);
  pm_board_model u_pm_board_model (.*);

  initial begin
    forever #12.5 aclk = ~aclk;
  end

  // ----------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic hang;
    failures++;
    $display("ERROR %0t wait bound used up", $time);
    tally_and_finish();
  endtask : hang

  task automatic chk(input logic [31:0] got, input logic [31:0] e,
                     input string w);
    total_checks++;
    if (got !== e) begin
      failures++;
      $display("ERROR %0t %s got %h exp %h", $time, w, got, e);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  task automatic axi_write(input logic [5:0] i, input logic [7:0] d,
                           output logic [1:0] r);
    int n;
    logic aw_ok, w_ok, b_ok;
    n = 0;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    b_ok = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_ok && w_ok && b_ok)) begin
      @(posedge aclk);
      n++;
      if (n > 50) hang();
      if (s_axi_awready && !aw_ok) begin
        aw_ok = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wready && !w_ok) begin
        w_ok = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
      if (s_axi_bvalid && !b_ok) begin
        b_ok = 1'h1;
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
      end
    end
  endtask : axi_write

  task automatic axi_read(input logic [5:0] i, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    logic ar_ok, r_ok;
    n = 0;
    ar_ok = 1'h0;
    r_ok = 1'h0;
    @(posedge aclk);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!r_ok) begin
      @(posedge aclk);
      n++;
      if (n > 50) hang();
      if (s_axi_arready && !ar_ok) begin
        ar_ok = 1'h1;
        s_axi_arvalid <= 1'h0;
      end
      if (s_axi_rvalid) begin
        r_ok = 1'h1;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
      end
    end
  endtask : axi_read

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [1:0] r;
    axi_write(i, d, r);
    chk(r, 32'h0, "write resp");
  endtask : wr

  task automatic rd_chk(input logic [5:0] i, input logic [31:0] e,
                        input string w);
    logic [31:0] v;
    logic [1:0] r;
    axi_read(i, v, r);
    chk(r, 32'h0, w);
    chk(v, e, w);
  endtask : rd_chk

  // ----------------------------------------------------------
  // Tests
  // ----------------------------------------------------------
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    tick(3);
    chk(cfg_port_addr, 32'h0370, "addr");
    chk({clock48_select_bit, keyboard_enable_bit, clear_defaults_bit},
        32'h5, "straps");
    chk({ser_pad_oe, ser_pad_out}, 32'hF5, "serial");
    rd_chk(`PM_IDX_GLOBAL_OPTION_CFG, 32'h41, "opt");
    rd_chk(`PM_IDX_GLOBAL_OPTION_CFG2, 32'h40, "opt2");
    rd_chk(`PM_IDX_PIN_SELECT_CFG_A, 32'h0, "cfga");
    rd_chk(`PM_IDX_PIN_SELECT_CFG_B, 32'h0, "cfgb");
    wr(`PM_IDX_GLOBAL_OPTION_CFG, 8'h04);
    tick(2);
    chk({clock48_select_bit, keyboard_enable_bit}, 32'h1, "opt");
    $display("straps test done");
    panel_switch_out <= 1'h1;
    for (int i = 0; i < 2; i++) begin
      ext_level <= i ? 6'h10 : 6'h28;
      tick(3);
      chk({mux_pad_oe[2], mux_pad_out[2]}, 32'h2, "panel out");
      chk({panel_switch_in, consumer_ir_rx, fast_ir_rx},
          i ? 32'h2 : 32'h5, "inputs");
    end
    wr(`PM_IDX_PM_CTL, 8'h01);
    pm_event <= 1'h1;
    tick(3);
    chk({mux_pad_oe[1], mux_pad_out[1]}, 32'h2, "smi low");
    pm_event <= 1'h0;
    tick(3);
    chk(mux_pad_in[1], 32'h1, "smi released");
    $display("default pins test done");
    wr(`PM_IDX_PORT2_ALT, 8'h00);
    wr(`PM_IDX_PORT2_DIR, 8'h3F);
    wr(`PM_IDX_PORT2_DATA, 8'h2A);
    wr(`PM_IDX_PIN_SELECT_CFG_B, 8'h68);
    wr(`PM_IDX_PIN_SELECT_CFG_A, 8'h18);
    tick(3);
    chk({mux_pad_oe, mux_pad_out}, 32'hFEA, "port");
    chk({panel_switch_in, consumer_ir_rx, fast_ir_rx}, 32'h7, "unrouted");
    rd_chk(`PM_IDX_PORT2_PINS, 32'h2A, "pins");
    keyboard_ctl_line_out <= 6'h16;
    keyboard_ctl_line_oe <= 6'h3F;
    wr(`PM_IDX_PORT2_ALT, 8'h3F);
    tick(3);
    chk(mux_pad_out, 32'h0D, "alternate");
    $display("port line test done");
    keyboard_ctl_line_out <= 6'h01;
    ir_module_sel0 <= 1'h1;
    wr(`PM_IDX_PIN_SELECT_CFG_B, 8'h10);
    wr(`PM_IDX_PIN_SELECT_CFG_A, 8'h24);
    tick(3);
    chk({mux_pad_out[5:4], mux_pad_out[1]}, 32'h6, "routes");
    chk(keyboard_ctl_line_in, 32'h27, "kin");
    $display("keyboard route test done");
    axi_read(6'h3F, rd_v, rsp);
    chk(rsp, 32'h2, "unmapped");
    axi_write(`PM_IDX_PORT2_PINS, 8'h00, rsp);
    chk(rsp, 32'h2, "read-only");
    $display("refusal test done");
    tally_and_finish();
  end
endmodule : pm_pin_mux_tb_top
